// >>> hw/srw_pkg.sv
// Shared constants, types and carriers of the reset supervisor.
// Assumes a single 100 MHz system clock and word-aligned Avalon-MM access.
package srw_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_NS      = 10;
  localparam int TICK_NS     = 6400000;
  localparam int HALF_NS     = TICK_NS / 2;
  localparam int HALF_CYC    = HALF_NS / CLK_NS;
  localparam int WD_EXT_MULT = 128;
  localparam int WD_MAX_US   = 296000000;
  localparam int WD_MAX_HALF = WD_MAX_US / (HALF_NS / 1000);
  localparam int MR_DEB_NS   = 1000;
  localparam int MR_DEB_CYC  = (MR_DEB_NS + CLK_NS - 1) / CLK_NS;
  localparam int SAMP_NS     = 1000;
  localparam int SAMP_CYC    = (SAMP_NS + CLK_NS - 1) / CLK_NS;

  // ************************************************************
  // Register map and fields
  // ************************************************************
  localparam logic [4:0]  REG_CTRL     = 5'h00;
  localparam logic [4:0]  REG_STATUS   = 5'h04;
  localparam logic [4:0]  REG_IRQ_STAT = 5'h08;
  localparam logic [4:0]  REG_IRQ_CLR  = 5'h0c;
  localparam logic [4:0]  REG_IRQ_EN   = 5'h10;
  localparam logic [4:0]  REG_WD_CNT   = 5'h14;
  localparam int          CTRL_EN_BIT  = 0;
  localparam int          CTRL_KICK_BIT = 1;
  localparam int          IRQ_UV_BIT   = 0;
  localparam int          IRQ_MR_BIT   = 1;
  localparam int          IRQ_WD_BIT   = 2;
  localparam logic        CTRL_EN_RST  = 1'h1;
  localparam logic [2:0]  IRQ_EN_RST   = 3'h0;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    ST_ASSERT = 3'b001,
    ST_HOLD   = 3'b010,
    ST_RUN    = 3'b100
  } srw_state_t;

  typedef enum logic [1:0] {
    CAP_GND   = 2'h0,
    CAP_SMALL = 2'h1,
    CAP_OK    = 2'h2,
    CAP_LARGE = 2'h3
  } srw_cap_class_t;

  typedef struct packed {
    srw_cap_class_t cls;
    logic [15:0]    ticks;
  } srw_cap_t;

  typedef struct packed {
    logic     below_trip;
    logic     above_hyst;
    logic     mr_n;
    logic     kick;
    logic     sel;
    srw_cap_t cap;
  } srw_pins_t;

  localparam srw_pins_t PINS_RST = '{below_trip: 1'b1, above_hyst: 1'b0,
                                     mr_n: 1'b1, kick: 1'b0, sel: 1'b0,
                                     cap: '{cls: CAP_GND, ticks: 16'h0000}};

  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
  } srw_avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } srw_avs_rsp_t;

endpackage

// >>> hw/srw_supervisor.sv
// Reset supervisor with watchdog: drives the host's active-low reset.
// Assumes capacitor settings arrive as static digital codes and that
// software reaches the control registers over Avalon-MM.
`timescale 1ns/10ps
// Overview of operation
// - Reset low while supply is below trip or manual reset is low.
// - After all causes clear, reset stays low for the hold period.
// - Watchdog expiry gives a reset pulse one hold period long.
// - Normal timeout is whole 6.4ms ticks plus 3.2ms.
// - Grounded watchdog timing input disables the watchdog entirely.
// - Hold period is a configured count, linear in the capacitor.
// - Manual reset holds reset low, then one hold period after release.
// - Watchdog counter clears on kick falling edge and during reset.
// - Range select high multiplies tick count by 128, keeps 3.2ms.
// - Any range select change clears the watchdog counter.
// - Supply release timing starts only above trip plus hysteresis.
// - Bouncing manual reset switch tolerated without external debounce.
// - Counter stays cleared during reset, resumes once the timing value is sampled.
// - Timing value sampled after release; aborted if reset falls.
// - Too small capacitance gives zero timeout, reset repeats.
// - Too large capacitance or over 296s disables the watchdog.
module srw_supervisor
  import srw_pkg::*;
#(
  parameter int HALF_CYCLES = HALF_CYC
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  // Avalon-MM register slave
  input  wire srw_avs_req_t avs_req,
  output      srw_avs_rsp_t avs_rsp,
  // Supply monitor indications
  input  wire logic         supply_below_trip,
  input  wire logic         supply_above_hyst,
  // Host-side pins
  input  wire logic         manual_reset_n,
  input  wire logic         watchdog_kick_in,
  input  wire logic         watchdog_range_sel,
  // Capacitor settings
  input  wire srw_cap_t     watchdog_timing_cap,
  input  wire logic [31:0]  reset_timing_cap,
  // Outputs
  output      logic         reset_out_n,
  output      logic         irq
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    srw_state_t  st;
    logic [31:0] hold_cnt;
    logic        uv;
    logic        mr_low;
    logic [7:0]  deb_cnt;
    logic        kick_prev;
    logic        sel_prev;
    logic [24:0] wd_cnt;
    logic [7:0]  samp_cnt;
    logic        samp_done;
    srw_cap_t    cap;
    logic        sw_en;
    logic        kick_req;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_en;
    logic        waitreq;
    logic [31:0] rdata;
    logic        reset_n;
    logic        irq;
  } srw_core_t;

  srw_core_t   r;
  srw_core_t   r_nxt;
  srw_pins_t   pin;
  logic        half_tick;
  logic        cause;
  logic        kick_fall;
  logic        sel_chg;
  logic [24:0] limit;
  logic        wd_inf;
  logic        wd_live;
  logic        wd_exp;
  logic [31:0] hold_lim;
  logic [2:0]  ev;
  logic [2:0]  clr;
  logic [31:0] rd;

  // Half-tick count of a timeout: 2*ticks(*128) + 1 half tick
  function automatic logic [24:0] wd_limit(input srw_cap_t c,
                                           input logic     ext);
    logic [24:0] base;
    base = 25'(c.ticks) * 25'd2;
    if (ext) begin
      base = base * 25'(WD_EXT_MULT);
    end
    return base + 25'h0000001;
  endfunction

  // ************************************************************
  // Input synchronisers and time base
  // ************************************************************
  srw_sync #(
    .W   ($bits(srw_pins_t)),
    .RST (PINS_RST)
  ) u_sync (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .d       ({supply_below_trip, supply_above_hyst, manual_reset_n,
               watchdog_kick_in, watchdog_range_sel, watchdog_timing_cap}),
    .q       (pin)
  );

  srw_tick #(
    .HALF_CYCLES (HALF_CYCLES)
  ) u_tick (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .half_tick (half_tick)
  );

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    r_nxt      = r;
    r_nxt.waitreq  = 1'b1;
    r_nxt.kick_req = 1'b0;

    // Trip below threshold, release only above hysteresis
    if (pin.below_trip) begin
      r_nxt.uv = 1'b1;
    end else if (pin.above_hyst) begin
      r_nxt.uv = 1'b0;
    end

    // Level must hold for the whole window; switch bounce restarts it
    if ((!pin.mr_n) != r.mr_low) begin
      if (r.deb_cnt == 8'(MR_DEB_CYC - 1)) begin
        r_nxt.mr_low  = !pin.mr_n;
        r_nxt.deb_cnt = 8'h00;
      end else begin
        r_nxt.deb_cnt = r.deb_cnt + 8'h01;
      end
    end else begin
      r_nxt.deb_cnt = 8'h00;
    end

    cause     = r.uv | r.mr_low;
    kick_fall = (r.kick_prev & ~pin.kick) | r.kick_req;
    sel_chg   = pin.sel ^ r.sel_prev;
    r_nxt.kick_prev = pin.kick;
    r_nxt.sel_prev  = pin.sel;
    hold_lim  = (reset_timing_cap == 32'h00000000) ? 32'h00000001
                                                   : reset_timing_cap;

    // Watchdog limit and expiry
    limit   = wd_limit(r.cap, pin.sel);
    wd_inf  = (r.cap.cls == CAP_LARGE) ||
              ((r.cap.cls == CAP_OK) &&
               (limit > 25'(WD_MAX_HALF)));
    wd_live = (r.st == ST_RUN) && r.samp_done && r.sw_en &&
              (r.cap.cls != CAP_GND) && !wd_inf;
    // A range change clears first; an old count never meets a new limit
    wd_exp  = wd_live && ((r.cap.cls == CAP_SMALL) ||
                          (!sel_chg && (r.wd_cnt >= limit)));

    // Reset sequencer
    case (r.st)
      ST_ASSERT: begin
        r_nxt.hold_cnt = 32'h00000000;
        if (!cause) begin
          r_nxt.st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (cause) begin
          r_nxt.st       = ST_ASSERT;
          r_nxt.hold_cnt = 32'h00000000;
        end else if (r.hold_cnt >= hold_lim - 32'h00000001) begin
          r_nxt.st       = ST_RUN;
          r_nxt.hold_cnt = 32'h00000000;
        end else begin
          r_nxt.hold_cnt = r.hold_cnt + 32'h00000001;
        end
      end
      ST_RUN: begin
        if (cause) begin
          r_nxt.st = ST_ASSERT;
        end else if (wd_exp) begin
          r_nxt.st       = ST_HOLD;
          r_nxt.hold_cnt = 32'h00000000;
        end
      end
      default: begin
        r_nxt.st = ST_ASSERT;
      end
    endcase

    // Watchdog counter
    if ((r.st != ST_RUN) || (r_nxt.st != ST_RUN) || kick_fall ||
        sel_chg) begin
      r_nxt.wd_cnt = 25'h0000000;
    end else if (wd_live && half_tick) begin
      r_nxt.wd_cnt = r.wd_cnt + 25'h0000001;
    end

    // Sampling of the timing setting after each release
    if ((r.st != ST_RUN) || (r_nxt.st != ST_RUN)) begin
      r_nxt.samp_cnt  = 8'h00;
      r_nxt.samp_done = 1'b0;
    end else if (!r.samp_done) begin
      if (r.samp_cnt == 8'(SAMP_CYC - 1)) begin
        r_nxt.samp_done = 1'b1;
        r_nxt.cap       = pin.cap;
      end else begin
        r_nxt.samp_cnt = r.samp_cnt + 8'h01;
      end
    end

    // Events
    ev = 3'h0;
    ev[IRQ_UV_BIT] = r_nxt.uv & ~r.uv;
    ev[IRQ_MR_BIT] = r_nxt.mr_low & ~r.mr_low;
    ev[IRQ_WD_BIT] = wd_exp;

    // Read mux
    case (avs_req.address)
      REG_CTRL:     rd = {31'h0, r.sw_en};
      REG_STATUS:   rd = {21'h0, r.cap.cls, r.samp_done, wd_inf,
                          pin.sel, r.mr_low, r.uv, r.st, r.reset_n};
      REG_IRQ_STAT: rd = {29'h0, r.irq_stat};
      REG_IRQ_EN:   rd = {29'h0, r.irq_en};
      REG_WD_CNT:   rd = {7'h0, r.wd_cnt};
      default:      rd = 32'h00000000;
    endcase

    // Bus: one busy cycle, then a single-cycle answer
    clr = 3'h0;
    if (r.waitreq) begin
      if (avs_req.read || avs_req.write) begin
        r_nxt.waitreq = 1'b0;
        r_nxt.rdata   = avs_req.read ? rd : 32'h00000000;
      end
    end else if (avs_req.write) begin
      case (avs_req.address)
        REG_CTRL: begin
          r_nxt.sw_en    = avs_req.writedata[CTRL_EN_BIT];
          r_nxt.kick_req = avs_req.writedata[CTRL_KICK_BIT];
        end
        REG_IRQ_CLR: clr = avs_req.writedata[2:0];
        REG_IRQ_EN:  r_nxt.irq_en = avs_req.writedata[2:0];
        default: begin
        end
      endcase
    end

    // A new event beats a simultaneous clear
    r_nxt.irq_stat = (r.irq_stat & ~clr) | ev;
    r_nxt.irq      = |(r_nxt.irq_stat & r_nxt.irq_en);
    r_nxt.reset_n  = (r_nxt.st == ST_RUN);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '{st: ST_ASSERT, hold_cnt: 32'h00000000, uv: 1'b1,
             mr_low: 1'b0, deb_cnt: 8'h00, kick_prev: 1'b0,
             sel_prev: 1'b0, wd_cnt: 25'h0000000, samp_cnt: 8'h00,
             samp_done: 1'b0, cap: '{cls: CAP_GND, ticks: 16'h0000},
             sw_en: CTRL_EN_RST, kick_req: 1'b0, irq_stat: 3'h0,
             irq_en: IRQ_EN_RST, waitreq: 1'b1, rdata: 32'h00000000,
             reset_n: 1'b0, irq: 1'b0};
    end else begin
      r <= r_nxt;
    end
  end

  assign avs_rsp     = '{readdata: r.rdata, waitrequest: r.waitreq};
  assign reset_out_n = r.reset_n;
  assign irq         = r.irq;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_wd_fire;
    wd_exp ##1 (!reset_out_n && r.st == ST_HOLD && r.hold_cnt == 32'h0);
  endsequence

  property p_cause_low;
    (r.uv || r.mr_low) |=> !reset_out_n;
  endproperty
  a_cause_low: assert property (p_cause_low)
    else $error("reset high while a cause is active");

  property p_hold_len;
    $rose(reset_out_n) |-> ($past(r.st) == ST_HOLD) &&
      ($past(r.hold_cnt) == $past(hold_lim) - 32'h1);
  endproperty
  a_hold_len: assert property (p_hold_len)
    else $error("reset released before hold period ended");

  property p_wd_pulse;
    wd_exp && !cause |-> s_wd_fire;
  endproperty
  a_wd_pulse: assert property (p_wd_pulse)
    else $error("watchdog expiry gave no reset pulse");

  property p_normal_to;
    (wd_exp && r.cap.cls == CAP_OK && !pin.sel) |->
      r.wd_cnt == 25'(r.cap.ticks) * 25'd2 + 25'd1;
  endproperty
  a_normal_to: assert property (p_normal_to)
    else $error("normal timeout length wrong");

  property p_ext_to;
    (wd_exp && r.cap.cls == CAP_OK && pin.sel) |->
      r.wd_cnt == 25'(r.cap.ticks) * 25'd256 + 25'd1;
  endproperty
  a_ext_to: assert property (p_ext_to)
    else $error("extended timeout length wrong");

  property p_gnd_off;
    (r.cap.cls == CAP_GND || wd_inf) |-> !wd_exp && !wd_live;
  endproperty
  a_gnd_off: assert property (p_gnd_off)
    else $error("disabled watchdog fired");

  property p_kick_clr;
    (r.kick_prev && !pin.kick) |=> r.wd_cnt == 25'h0;
  endproperty
  a_kick_clr: assert property (p_kick_clr)
    else $error("kick edge did not clear the counter");

  property p_sel_clr;
    (pin.sel != r.sel_prev) |=> r.wd_cnt == 25'h0;
  endproperty
  a_sel_clr: assert property (p_sel_clr)
    else $error("range change did not clear the counter");

  property p_uv_hyst;
    $fell(r.uv) |-> $past(pin.above_hyst) && !$past(pin.below_trip);
  endproperty
  a_uv_hyst: assert property (p_uv_hyst)
    else $error("supply fault released without hysteresis");

  property p_mr_deb;
    $changed(r.mr_low) |-> $past(r.deb_cnt) == 8'(MR_DEB_CYC - 1);
  endproperty
  a_mr_deb: assert property (p_mr_deb)
    else $error("manual reset accepted before debounce window");

  property p_rst_clear;
    !reset_out_n |-> r.wd_cnt == 25'h0 && !r.samp_done;
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("counter or sampling alive during reset");

  property p_small_cap;
    (r.cap.cls == CAP_SMALL && wd_live) |-> wd_exp;
  endproperty
  a_small_cap: assert property (p_small_cap)
    else $error("zero timeout did not fire at once");

endmodule

// >>> hw/srw_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to sys_clk.
`timescale 1ns/10ps
module srw_sync
  import srw_pkg::*;
#(
  parameter int              W   = 1,
  parameter logic [W-1:0]    RST = '0
) (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          arst_n,
  // Data
  input  wire logic [W-1:0]  d,
  output      logic [W-1:0]  q
);

  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] q;
  } srw_sync_st_t;

  srw_sync_st_t r;
  srw_sync_st_t r_nxt;

  always_comb begin
    r_nxt     = r;
    r_nxt.ff1 = d;
    r_nxt.ff2 = r.ff1;
    r_nxt.ff3 = r.ff2;
    // Only bits where the last two stages agree move on
    r_nxt.q   = (r.ff2 & r.ff3) | (r.q & (r.ff2 ^ r.ff3));
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '{ff1: RST, ff2: RST, ff3: RST, q: RST};
    end else begin
      r <= r_nxt;
    end
  end

  assign q = r.q;

endmodule

// >>> hw/srw_tick.sv
// Free-running half-tick enable generator, the watchdog time base.
// Assumes sys_clk runs continuously.
`timescale 1ns/10ps
module srw_tick
  import srw_pkg::*;
#(
  parameter int HALF_CYCLES = HALF_CYC
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // Enable out
  output      logic half_tick
);

  typedef struct packed {
    logic [23:0] cnt;
    logic        pulse;
  } srw_tick_st_t;

  srw_tick_st_t r;
  srw_tick_st_t r_nxt;

  always_comb begin
    r_nxt       = r;
    r_nxt.pulse = 1'b0;
    if (r.cnt == 24'(HALF_CYCLES - 1)) begin
      r_nxt.cnt   = 24'h000000;
      r_nxt.pulse = 1'b1;
    end else begin
      r_nxt.cnt = r.cnt + 24'h000001;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '{cnt: 24'h000000, pulse: 1'b0};
    end else begin
      r <= r_nxt;
    end
  end

  assign half_tick = r.pulse;

endmodule

// >>> test/srw_host_model.sv
// Host processor model: answers the supervisor's reset and kicks it.
// Assumes the bench enables kicking and that kicks start on rising edges.
`timescale 1ns/10ps
module srw_host_model #(
  parameter int PERIOD = 40
) (
  // Clock and control
  input  wire logic sys_clk,
  input  wire logic kick_en,
  // Supervisor pins
  input  wire logic reset_out_n,
  output      logic watchdog_kick_in
);
  int cnt = 0;

  initial watchdog_kick_in = 1'b1;

  // Square wave, one falling edge each period; idles high in reset
  always @(posedge sys_clk) begin
    if (reset_out_n !== 1'b1) begin
      cnt <= 0;
      watchdog_kick_in <= 1'b1;
    end else if (kick_en !== 1'b1) begin
      // Disabled: hold the level, so the last kick is a full one
      cnt <= 0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      watchdog_kick_in <= (cnt < PERIOD / 2);
    end
  end
endmodule

// >>> test/supervisor_reset_watchdog_tb.sv
// Self-checking bench of the reset supervisor with watchdog.
// Assumes the package, the design and the host model are compiled first.
`timescale 1ns/10ps
module supervisor_reset_watchdog_tb
  import srw_pkg::*;
;
  localparam int HALF  = 10;
  localparam int HOLD  = 50;
  localparam int TICKS = 3;
  localparam int WD_LO = 2 * TICKS * HALF;
  localparam int EXT   = SAMP_CYC + 256 * TICKS * HALF;
  localparam int LIMIT = 30000;

  typedef struct packed {
    logic        wr;
    logic [4:0]  addr;
    logic [31:0] data;
  } srw_tb_row_t;

  logic         sys_clk;
  logic         arst_n;
  srw_avs_req_t avs_req;
  srw_avs_rsp_t avs_rsp;
  logic         supply_below_trip;
  logic         supply_above_hyst;
  logic         manual_reset_n;
  logic         watchdog_kick_in;
  logic         watchdog_range_sel;
  srw_cap_t     watchdog_timing_cap;
  logic [31:0]  reset_timing_cap;
  logic         reset_out_n;
  logic         irq;
  logic         kick_en;
  logic         low_seen;
  logic [31:0]  rd;
  int           fail_count = 0;
  int           n_checks = 0;
  int           cyc = 0;
  int           n;
  // Data column: write data, or expected read data
  srw_tb_row_t  rows [11] = '{
    '{1'b0, REG_IRQ_EN, 32'h0}, '{1'b0, REG_CTRL, 32'h1},
    '{1'b0, REG_STATUS, 32'h9},
    '{1'b1, REG_IRQ_EN, 32'h5}, '{1'b0, REG_IRQ_EN, 32'h5},
    '{1'b1, REG_CTRL, 32'h3},   '{1'b0, REG_CTRL, 32'h1},
    '{1'b1, REG_IRQ_EN, 32'h0}, '{1'b1, 5'h1c, 32'hffffffff},
    '{1'b0, 5'h1c, 32'h0},      '{1'b0, 5'h18, 32'h0}};

  srw_supervisor #(.HALF_CYCLES(HALF)) srw_supervisor_inst (
    .sys_clk(sys_clk), .arst_n(arst_n), .avs_req(avs_req),
    .avs_rsp(avs_rsp), .supply_below_trip(supply_below_trip),
    .supply_above_hyst(supply_above_hyst),
    .manual_reset_n(manual_reset_n), .watchdog_kick_in(watchdog_kick_in),
    .watchdog_range_sel(watchdog_range_sel),
    .watchdog_timing_cap(watchdog_timing_cap),
    .reset_timing_cap(reset_timing_cap), .reset_out_n(reset_out_n),
    .irq(irq));

  srw_host_model srw_host_model_inst (
    .sys_clk(sys_clk), .kick_en(kick_en), .reset_out_n(reset_out_n),
    .watchdog_kick_in(watchdog_kick_in));

  // ************************************************************
  // Helpers
  // ************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] inr(input int lo, input int hi);
    return 32'(n >= lo && n <= hi);
  endfunction

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] wd);
    int k;
    k = 0;
    avs_req <= '{read: ~wr, write: wr, address: a, writedata: wd};
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_rsp.waitrequest !== 1'b0 && k < 50);
    if (k >= 50) chk(32'h0, 32'h1);
    rd = avs_rsp.readdata;
    avs_req <= '{read: 1'b0, write: 1'b0, address: a, writedata: wd};
    @(posedge sys_clk);
  endtask

  task automatic wait_rst(input logic lvl, input int max);
    n = 0;
    while (reset_out_n !== lvl && n < max) begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  task automatic hold_high(input int cycles);
    repeat (cycles) begin
      @(posedge sys_clk);
      if (reset_out_n !== 1'b1) low_seen = 1'b1;
    end
  endtask

  task automatic wrap_up();
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Hang guard, well above the expected run length
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      chk(32'h0, 32'h1);
      wrap_up();
    end
  end

  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    arst_n = 1'b0;
    avs_req = '0;
    supply_below_trip = 1'b1;
    supply_above_hyst = 1'b0;
    manual_reset_n = 1'b1;
    watchdog_range_sel = 1'b0;
    watchdog_timing_cap = '{cls: CAP_OK, ticks: 16'h0003};
    reset_timing_cap = 32'h00000032;
    kick_en = 1'b1;
    low_seen = 1'b0;
    repeat (6) @(posedge sys_clk);
    chk(reset_out_n, 32'h0);
    chk(irq, 32'h0);
    chk(avs_rsp.waitrequest, 32'h1);
    arst_n <= 1'b1;
    supply_below_trip <= 1'b0;
    repeat (200) @(posedge sys_clk);
    chk(reset_out_n, 32'h0);
    supply_above_hyst <= 1'b1;
    wait_rst(1'b1, 500);
    chk(inr(HOLD + 2, HOLD + 8), 32'h1);
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].addr, rows[i].data);
      if (!rows[i].wr) chk(rd, rows[i].data);
    end
    hold_high(1500);
    chk(low_seen, 32'h0);
    // Expiry, then interrupt raise, mask and clear
    bus(1'b1, REG_IRQ_CLR, 32'h7);
    bus(1'b1, REG_IRQ_EN, 32'h4);
    chk(irq, 32'h0);
    @(negedge watchdog_kick_in);
    kick_en <= 1'b0;
    wait_rst(1'b0, 200);
    chk(inr(WD_LO + 2, WD_LO + HALF + 8), 32'h1);
    watchdog_timing_cap <= '{cls: CAP_SMALL, ticks: 16'h0003};
    wait_rst(1'b1, 200);
    chk(inr(HOLD - 1, HOLD + 1), 32'h1);
    bus(1'b0, REG_IRQ_STAT, 32'h0);
    chk(rd & 32'h4, 32'h4);
    chk(irq, 32'h1);
    bus(1'b1, REG_IRQ_EN, 32'h0);
    @(posedge sys_clk);
    chk(irq, 32'h0);
    bus(1'b1, REG_IRQ_EN, 32'h4);
    @(posedge sys_clk);
    chk(irq, 32'h1);
    bus(1'b1, REG_IRQ_CLR, 32'h4);
    @(posedge sys_clk);
    chk(irq, 32'h0);
    wait_rst(1'b0, 200);
    chk(inr(60, 100), 32'h1);
    watchdog_timing_cap <= '{cls: CAP_GND, ticks: 16'h0003};
    wait_rst(1'b1, 200);
    hold_high(1000);
    chk(low_seen, 32'h0);
    // Switch bounce shorter than the filter, then a real press
    watchdog_timing_cap <= '{cls: CAP_OK, ticks: 16'h0003};
    repeat (3) begin
      manual_reset_n <= 1'b0;
      hold_high(30);
      manual_reset_n <= 1'b1;
      hold_high(30);
    end
    chk(low_seen, 32'h0);
    manual_reset_n <= 1'b0;
    wait_rst(1'b0, 300);
    chk(inr(MR_DEB_CYC + 2, MR_DEB_CYC + 8), 32'h1);
    bus(1'b0, REG_WD_CNT, 32'h0);
    chk(rd, 32'h0);
    repeat (200) @(posedge sys_clk);
    chk(reset_out_n, 32'h0);
    watchdog_range_sel <= 1'b1;
    manual_reset_n <= 1'b1;
    wait_rst(1'b1, 400);
    chk(inr(MR_DEB_CYC + HOLD + 2, MR_DEB_CYC + HOLD + 9), 32'h1);
    wait_rst(1'b0, 9000);
    chk(inr(EXT - HALF, EXT + HALF + 10), 32'h1);
    wait_rst(1'b1, 200);
    // Each toggle must restart the count, or a short window fires
    for (int i = 0; i < 21; i++) begin
      watchdog_range_sel <= ~watchdog_range_sel;
      hold_high(40);
    end
    chk(low_seen, 32'h0);
    wait_rst(1'b0, 150);
    chk(inr(WD_LO - 38, WD_LO - 40 + HALF + 8), 32'h1);
    wrap_up();
  end
endmodule
